/* hdl/cell_extract_pkg.sv */
// Constants and types for the receive cell extraction readout block
package cell_extract_pkg;
	localparam logic [11:0] OFS_IRQ_FLAGS = 12'h70B;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h70F;
	localparam logic [11:0] OFS_MEM_CTRL = 12'h713;
	localparam logic [11:0] OFS_DATA_MSB = 12'h714;
	localparam logic [11:0] OFS_DATA_B2 = 12'h715;
	localparam logic [11:0] OFS_DATA_B1 = 12'h716;
	localparam logic [11:0] OFS_DATA_LSB = 12'h717;
	localparam int BIT_EXTRACT_IRQ = 5;
	localparam int BIT_EXTRACT_RSTN = 4;
	localparam int BIT_CELL_PRESENT = 3;
	localparam logic [7:0] MASK_RESET = 8'h20;
	localparam logic [7:0] MEM_CTRL_RESET = 8'h16;
	localparam logic [7:0] MEM_CTRL_WMASK = 8'h17;
	localparam int CELL_WORDS = 14;
	localparam int WORD_PTR_W = 4;
	localparam int CELL_SLOTS = 2;
	localparam int SLOT_W = 1;
	localparam logic [3:0] LAST_WORD = 4'hD;

	typedef struct packed {
		logic [11:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} cpu_req_t;

	typedef struct packed {
		logic valid;
		logic [3:0] index;
		logic [31:0] data;
	} cell_word_t;
endpackage

/* hdl/cell_store.sv */
// Two-cell word store for extracted cells, with cell-level occupancy
`timescale 1ns/1ps
module cell_store
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic flush_in,
	input wire cell_extract_pkg::cell_word_t wr_in,
	input wire logic rd_adv_in,
	output logic [31:0] rd_word_out,
	output logic cell_done_out,
	output logic present_out
);
	logic [31:0] mem [cell_extract_pkg::CELL_SLOTS][cell_extract_pkg::CELL_WORDS];
	logic [cell_extract_pkg::SLOT_W-1:0] wslot, rslot;
	logic [cell_extract_pkg::SLOT_W-1:0] next_wslot, next_rslot;
	logic [cell_extract_pkg::WORD_PTR_W-1:0] rptr, next_rptr;
	logic [1:0] count, next_count;
	logic done, next_done;
	logic write_last;
	logic read_last;

	// A word arriving while both slots are full is dropped; a cell counts only if its last word is stored
	assign write_last = wr_in.valid && wr_in.index == cell_extract_pkg::LAST_WORD
		&& count != 2'h2;
	assign read_last = rd_adv_in && count != 2'h0
		&& rptr == cell_extract_pkg::LAST_WORD;

	always_comb
	begin
		next_wslot = wslot;
		next_rslot = rslot;
		next_rptr = rptr;
		next_count = count;
		next_done = write_last;
		if (flush_in)
		begin
			next_wslot = '0;
			next_rslot = '0;
			next_rptr = '0;
			next_count = 2'h0;
			next_done = 1'b0;
		end
		else
		begin
			if (write_last)
				next_wslot = wslot + 1'b1;
			if (rd_adv_in && count != 2'h0)
				next_rptr = read_last ? '0 : rptr + 1'b1;
			if (read_last)
				next_rslot = rslot + 1'b1;
			if (write_last && !read_last)
				next_count = count + 2'h1;
			else if (read_last && !write_last)
				next_count = count - 2'h1;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wslot <= '0;
			rslot <= '0;
			rptr <= '0;
			count <= 2'h0;
			done <= 1'b0;
			present_out <= 1'b0;
		end
		else
		begin
			wslot <= next_wslot;
			rslot <= next_rslot;
			rptr <= next_rptr;
			count <= next_count;
			done <= next_done;
			present_out <= next_count != 2'h0;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (wr_in.valid && count != 2'h2 && !flush_in)
			mem[wslot][wr_in.index] <= wr_in.data;
	end

	assign rd_word_out = mem[rslot][rptr];
	assign cell_done_out = done;
endmodule

/* hdl/rx_cell_extraction_readout.sv */
// Receive cell extraction buffer readout with interrupt and byte registers
`timescale 1ns/1ps
module rx_cell_extraction_readout
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [11:0] addr_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	input wire logic cell_word_valid_in,
	input wire logic [3:0] cell_word_index_in,
	input wire logic [31:0] cell_word_data_in,
	input wire logic [5:0] other_irq_events_in,
	output logic [7:0] rdata_out,
	output logic rdata_valid_out,
	output logic int_n_out
);
	cell_extract_pkg::cpu_req_t req;
	cell_extract_pkg::cell_word_t cell_word;
	logic [7:0] irq_flags, next_irq_flags;
	logic [7:0] irq_mask, next_irq_mask;
	logic [7:0] mem_ctrl, next_mem_ctrl;
	logic [7:0] next_rdata;
	logic next_rdata_valid;
	logic next_int_n;
	logic [31:0] cur_word;
	logic cell_done;
	logic present;
	logic flush;
	logic rd_adv;
	logic [7:0] events;
	logic [cell_extract_pkg::WORD_PTR_W-1:0] word_cnt, next_word_cnt;

	assign req = '{addr: addr_in, rd: rd_in, wr: wr_in, wdata: wdata_in};
	assign cell_word = '{valid: cell_word_valid_in,
		index: cell_word_index_in, data: cell_word_data_in};

	// Held reset bit low keeps the buffer empty until software releases it
	assign flush = !mem_ctrl[cell_extract_pkg::BIT_EXTRACT_RSTN];
	assign rd_adv = req.rd && req.addr == cell_extract_pkg::OFS_DATA_LSB;

	cell_store u_store
	(
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.flush_in(flush),
		.wr_in(cell_word),
		.rd_adv_in(rd_adv),
		.rd_word_out(cur_word),
		.cell_done_out(cell_done),
		.present_out(present)
	);

	always_comb
	begin
		events = 8'h00;
		events[cell_extract_pkg::BIT_EXTRACT_IRQ] = cell_done;
		events[4] = other_irq_events_in[5];
		events[3:0] = other_irq_events_in[3:0];
	end

	always_comb
	begin
		next_irq_flags = irq_flags;
		next_irq_mask = irq_mask;
		next_mem_ctrl = mem_ctrl;
		next_rdata = 8'h00;
		next_rdata_valid = req.rd;
		if (req.rd && req.addr == cell_extract_pkg::OFS_IRQ_FLAGS)
			next_irq_flags = 8'h00;
		// Set wins over a clear-on-read in the same cycle
		next_irq_flags = next_irq_flags | (events & 8'h3F);
		if (req.wr && req.addr == cell_extract_pkg::OFS_IRQ_MASK)
			next_irq_mask = req.wdata & 8'h3F;
		if (req.wr && req.addr == cell_extract_pkg::OFS_MEM_CTRL)
			next_mem_ctrl = (req.wdata & cell_extract_pkg::MEM_CTRL_WMASK)
				| (mem_ctrl & 8'h08);
		next_mem_ctrl[cell_extract_pkg::BIT_CELL_PRESENT] = present;
		if (req.rd)
		begin
			case (req.addr)
				cell_extract_pkg::OFS_IRQ_FLAGS: next_rdata = irq_flags;
				cell_extract_pkg::OFS_IRQ_MASK: next_rdata = irq_mask;
				cell_extract_pkg::OFS_MEM_CTRL: next_rdata = mem_ctrl;
				cell_extract_pkg::OFS_DATA_MSB: next_rdata = cur_word[31:24];
				cell_extract_pkg::OFS_DATA_B2: next_rdata = cur_word[23:16];
				cell_extract_pkg::OFS_DATA_B1: next_rdata = cur_word[15:8];
				cell_extract_pkg::OFS_DATA_LSB: next_rdata = cur_word[7:0];
				default: next_rdata = 8'h00;
			endcase
		end
		// Output follows the registered flags, so it lags the flag by one cycle
		next_int_n = !(|(irq_flags & irq_mask));
	end

	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			irq_flags <= 8'h00;
			irq_mask <= cell_extract_pkg::MASK_RESET;
			mem_ctrl <= cell_extract_pkg::MEM_CTRL_RESET;
			rdata_out <= 8'h00;
			rdata_valid_out <= 1'b0;
			int_n_out <= 1'b1;
		end
		else
		begin
			irq_flags <= next_irq_flags;
			irq_mask <= next_irq_mask;
			mem_ctrl <= next_mem_ctrl;
			rdata_out <= next_rdata;
			rdata_valid_out <= next_rdata_valid;
			int_n_out <= next_int_n;
		end
	end

	// Shadow of the store's word pointer, so cell length is checked here
	always_comb
	begin
		next_word_cnt = word_cnt;
		if (flush)
			next_word_cnt = '0;
		else if (rd_adv && present)
			next_word_cnt = (word_cnt == cell_extract_pkg::LAST_WORD) ? '0
				: word_cnt + 4'h1;
	end

	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			word_cnt <= '0;
		else
			word_cnt <= next_word_cnt;
	end

	AST_FLAG_SET: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		cell_done |=> irq_flags[5])
		else $error("extraction flag not set");
	AST_IRQ_LOW: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		cell_done && irq_mask[5] |-> ##2 !int_n_out)
		else $error("interrupt not asserted");
	AST_IRQ_REL: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		(irq_flags & irq_mask) == 8'h00 |=> int_n_out)
		else $error("interrupt not released");
	AST_CLR_READ: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		req.rd && req.addr == cell_extract_pkg::OFS_IRQ_FLAGS && !cell_done
		&& other_irq_events_in == 6'h00 |=> !irq_flags[5])
		else $error("flags not cleared on read");
	AST_BYTE3: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		req.rd && req.addr == cell_extract_pkg::OFS_DATA_MSB
		|=> rdata_out == $past(cur_word[31:24]))
		else $error("byte 3 wrong");
	AST_BYTE0: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		req.rd && req.addr == cell_extract_pkg::OFS_DATA_LSB
		|=> rdata_out == $past(cur_word[7:0]))
		else $error("byte 0 wrong");
	AST_PRESENT: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		##1 mem_ctrl[3] == $past(present))
		else $error("present flag mismatch");
	AST_FLUSH: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		flush [*2] |-> !present)
		else $error("buffer not flushed");

	// Read path, register housekeeping and cell length
	AST_BYTE2: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		req.rd && req.addr == cell_extract_pkg::OFS_DATA_B2
		|=> rdata_out == $past(cur_word[23:16]))
		else $error("byte 2 wrong");
	AST_BYTE1: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		req.rd && req.addr == cell_extract_pkg::OFS_DATA_B1
		|=> rdata_out == $past(cur_word[15:8]))
		else $error("byte 1 wrong");
	AST_RD_VALID: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		req.rd |=> rdata_valid_out)
		else $error("read answer missing");
	AST_RD_IDLE: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		!req.rd |=> !rdata_valid_out && rdata_out == 8'h00)
		else $error("read answer outside a read");
	AST_IRQ_HOLD: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		(irq_flags & irq_mask) != 8'h00 |=> !int_n_out)
		else $error("interrupt released early");
	AST_FLAGS_KEEP: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		!(req.rd && req.addr == cell_extract_pkg::OFS_IRQ_FLAGS)
		&& events == 8'h00 |=> irq_flags == $past(irq_flags))
		else $error("flags changed without cause");
	AST_MASK_WR: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		req.wr && req.addr == cell_extract_pkg::OFS_IRQ_MASK
		|=> irq_mask == ($past(req.wdata) & 8'h3F))
		else $error("enable write lost");
	AST_MASK_KEEP: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		!(req.wr && req.addr == cell_extract_pkg::OFS_IRQ_MASK)
		|=> $stable(irq_mask))
		else $error("enable changed without write");
	AST_CTRL_WR: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		req.wr && req.addr == cell_extract_pkg::OFS_MEM_CTRL
		|=> mem_ctrl[4] == $past(req.wdata[4]))
		else $error("buffer reset bit write lost");
	AST_CTRL_KEEP: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		!(req.wr && req.addr == cell_extract_pkg::OFS_MEM_CTRL)
		|=> $stable(mem_ctrl[4]))
		else $error("buffer reset bit changed without write");
	AST_FLUSH_QUIET: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		flush |=> !cell_done)
		else $error("cell completed during flush");
	AST_CELL_LEN: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		rd_adv && present && !flush
		&& word_cnt != cell_extract_pkg::LAST_WORD |=> present)
		else $error("cell left before its last word");
	AST_PRESENT_SEEN: assert property (@(posedge mclk_in)
		disable iff (!rstn_in)
		cell_done |-> present)
		else $error("new cell not shown as present");
endmodule

/* dv/test_rx_cell_extraction_readout.sv */
// Self-checking bench for the receive cell extraction readout block
`timescale 1ns/1ps
module test_rx_cell_extraction_readout;
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [11:0] addr_in = 12'h000;
	logic rd_in = 1'b0;
	logic wr_in = 1'b0;
	logic [7:0] wdata_in = 8'h00;
	logic cv = 1'b0;
	logic [3:0] ci = 4'h0;
	logic [31:0] cd = 32'h0;
	logic [5:0] ev = 6'h00;
	logic [7:0] rdata_out;
	logic rdata_valid_out;
	logic int_n_out;
	logic [31:0] cells [0:3][0:13];
	logic [7:0] got;
	logic [5:0] evr;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	int seed_ret;

	rx_cell_extraction_readout u_rx_cell_extraction_readout (
		.mclk_in(mclk_in), .rstn_in(rstn_in), .addr_in(addr_in),
		.rd_in(rd_in), .wr_in(wr_in), .wdata_in(wdata_in),
		.cell_word_valid_in(cv), .cell_word_index_in(ci),
		.cell_word_data_in(cd), .other_irq_events_in(ev),
		.rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out),
		.int_n_out(int_n_out));

	always #50 mclk_in = ~mclk_in;

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Whole run needs well under 2000 cycles
	always @(posedge mclk_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	function automatic logic [7:0] byte_of(input logic [31:0] w, input int b);
		return w[31-8*b -: 8];
	endfunction

	function automatic logic [7:0] ctrl_exp(input logic present);
		return 8'h16 | {4'h0, present, 3'h0};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	// The idle edge after each read keeps strobes from being reassigned
	task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
		addr_in = a;
		rd_in = 1'b1;
		step(1);
		rd_in = 1'b0;
		chk(rdata_valid_out, 1'b1);
		d = rdata_out;
		step(1);
		chk(rdata_valid_out, 1'b0);
		chk(rdata_out, 8'h00);
	endtask

	task automatic chk_rd(input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] d;
		reg_rd(a, d);
		chk(d, exp);
	endtask

	task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
		addr_in = a;
		wdata_in = d;
		wr_in = 1'b1;
		step(1);
		wr_in = 1'b0;
		step(1);
	endtask

	task automatic push(input int k);
		for (int w = 0; w < 14; w++)
		begin
			cv = 1'b1;
			ci = 4'(w);
			cd = cells[k][w];
			step(1);
		end
		cv = 1'b0;
		cd = ~cd;
		step(1);
	endtask

	// Byte 3 is read twice on word 0: only a byte 0 read may advance
	task automatic read_cell(input int k);
		for (int w = 0; w < 14; w++)
		begin
			if (w == 0)
				chk_rd(12'h714, byte_of(cells[k][0], 0));
			for (int b = 0; b < 4; b++)
				chk_rd(12'h714 + 12'(b), byte_of(cells[k][w], b));
		end
	endtask

	initial
	begin
		seed_ret = $urandom(32'hA549F7DE);
		foreach (cells[k, w])
			cells[k][w] = $urandom();
		cells[0][0] = 32'hFFFFFFFF;
		cells[0][13] = 32'h00000000;
		step(6);
		rstn_in = 1'b1;
		chk_rd(cell_extract_pkg::OFS_IRQ_MASK, 8'h20);
		chk_rd(cell_extract_pkg::OFS_MEM_CTRL, ctrl_exp(1'b0));
		chk_rd(cell_extract_pkg::OFS_IRQ_FLAGS, 8'h00);
		chk_rd(12'h7FF, 8'h00);
		chk(int_n_out, 1'b1);
		$display("Test reset values done");
		push(0);
		step(4);
		chk(int_n_out, 1'b0);
		chk_rd(cell_extract_pkg::OFS_MEM_CTRL, ctrl_exp(1'b1));
		chk_rd(cell_extract_pkg::OFS_IRQ_FLAGS, 8'h20);
		step(2);
		chk(int_n_out, 1'b1);
		chk_rd(cell_extract_pkg::OFS_IRQ_FLAGS, 8'h00);
		read_cell(0);
		chk_rd(cell_extract_pkg::OFS_MEM_CTRL, ctrl_exp(1'b0));
		$display("Test interrupt cell done");
		reg_wr(cell_extract_pkg::OFS_IRQ_MASK, 8'h00);
		push(1);
		push(2);
		push(3);
		step(4);
		chk(int_n_out, 1'b1);
		chk_rd(cell_extract_pkg::OFS_IRQ_FLAGS, 8'h20);
		read_cell(1);
		chk_rd(cell_extract_pkg::OFS_MEM_CTRL, ctrl_exp(1'b1));
		read_cell(2);
		chk_rd(cell_extract_pkg::OFS_MEM_CTRL, ctrl_exp(1'b0));
		$display("Test full buffer done");
		reg_rd(12'h717, got);
		chk_rd(cell_extract_pkg::OFS_MEM_CTRL, ctrl_exp(1'b0));
		push(3);
		read_cell(3);
		chk_rd(cell_extract_pkg::OFS_IRQ_FLAGS, 8'h20);
		evr = 6'($urandom());
		ev = evr;
		step(1);
		ev = 6'h00;
		step(2);
		chk_rd(cell_extract_pkg::OFS_IRQ_FLAGS, {3'h0, evr[5], evr[3:0]});
		chk(int_n_out, 1'b1);
		$display("Test empty read and events done");
		push(0);
		step(4);
		reg_wr(cell_extract_pkg::OFS_MEM_CTRL, 8'h0F);
		// Present bit trails the flush write by two edges
		step(1);
		chk_rd(cell_extract_pkg::OFS_MEM_CTRL, 8'h07);
		reg_wr(cell_extract_pkg::OFS_MEM_CTRL, 8'h16);
		chk_rd(cell_extract_pkg::OFS_MEM_CTRL, ctrl_exp(1'b0));
		push(1);
		read_cell(1);
		$display("Test flush done");
		tally_and_finish();
	end
endmodule
